/* design/ccr_pkg_field.sv */
package ccr_pkg;

  // ----------------------------------------------------------------
  // Register selects on the coprocessor move port
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_WINDOW_BASE = 2'h0;
  localparam logic [1:0] SEL_COH_BASE    = 2'h1;
  localparam logic [1:0] SEL_CFG0        = 2'h2;
  localparam logic [1:0] SEL_CFG1        = 2'h3;

  // ----------------------------------------------------------------
  // Window base field layout
  // ----------------------------------------------------------------
  localparam int WIN_BASE_LSB   = 11;
  localparam int WIN_BASE_W     = 18;
  localparam int WIN_EN_BIT     = 10;
  localparam int WIN_CTRL_BIT   = 9;
  localparam int WIN_COUNT_W    = 9;
  localparam int WIN_ADDR_LSB   = 15;
  localparam int WIN_BLOCK_LSB  = 6;
  localparam logic [WIN_COUNT_W-1:0] WIN_COUNT_RESET = 9'h002;
  localparam logic                   WIN_EN_RESET    = 1'b0;

  // ----------------------------------------------------------------
  // Coherence base field layout
  // ----------------------------------------------------------------
  localparam int COH_BASE_LSB = 11;
  localparam int COH_BASE_W   = 21;
  localparam int COH_PA_LSB   = 15;

  // ----------------------------------------------------------------
  // Config word 0 field positions and fixed values
  // ----------------------------------------------------------------
  localparam int CFG0_M_BIT    = 31;
  localparam int CFG0_UPKERN_LSB = 28;
  localparam int CFG0_USER_LSB   = 25;
  localparam int CFG0_ISP_BIT    = 24;
  localparam int CFG0_DSP_BIT    = 23;
  localparam int CFG0_CUSTOM_BIT = 22;
  localparam int CFG0_SBE_BIT    = 21;
  localparam int CFG0_MDU_BIT    = 20;
  localparam int CFG0_WC_BIT     = 19;
  localparam int CFG0_MERGE_BIT  = 18;
  localparam int CFG0_BURST_BIT  = 16;
  localparam int CFG0_ENDIAN_BIT = 15;
  localparam int CFG0_ATYPE_LSB  = 13;
  localparam int CFG0_AREV_LSB   = 10;
  localparam int CFG0_MT_LSB     = 7;
  localparam int CFG0_KERN0_LSB  = 0;
  localparam logic [1:0] ARCH_TYPE_VAL = 2'h0;
  localparam logic [2:0] ARCH_REV_VAL  = 3'h1;
  localparam logic       BURST_SEQ     = 1'b0;
  localparam logic       WC_RESET      = 1'b0;
  localparam logic       MERGE_RESET   = 1'b1;

  // ----------------------------------------------------------------
  // Config word 1 field positions
  // ----------------------------------------------------------------
  localparam int CFG1_M_BIT   = 31;
  localparam int CFG1_TLB_LSB = 25;
  localparam int CFG1_IS_LSB  = 22;
  localparam int CFG1_IL_LSB  = 19;
  localparam int CFG1_IA_LSB  = 16;
  localparam int CFG1_DS_LSB  = 13;
  localparam int CFG1_DL_LSB  = 10;
  localparam int CFG1_DASSOC_LSB = 7;
  localparam logic [2:0] ASSOC_DIRECT = 3'h0;
  localparam logic [2:0] ASSOC_4WAY   = 3'h3;
  localparam logic [2:0] LINE_NONE    = 3'h0;
  localparam logic [2:0] LINE_32B     = 3'h4;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MMU_TLB   = 3'b001,
    MMU_FIXED = 3'b011
  } ccr_mmu_e;

  typedef enum logic [2:0] {
    CCA_RSVD0    = 3'b000,
    CCA_RSVD1    = 3'b001,
    CCA_UNCACHED = 3'b010,
    CCA_WB_NONCO = 3'b011,
    CCA_CO_EXCL  = 3'b100,
    CCA_CO_SHARE = 3'b101,
    CCA_RSVD6    = 3'b110,
    CCA_UNC_ACC  = 3'b111
  } ccr_cca_e;

  localparam logic [2:0] CCA_FM_RESET  = 3'h2;
  localparam logic [2:0] CCA_TLB_VALUE = 3'h0;

endpackage

`timescale 1ns/10ps
`default_nettype none

module ccr_cca_field
  import ccr_pkg::*;
#(
  parameter logic       WRITABLE  = 1'b1,
  parameter logic [2:0] RESET_VAL = CCA_FM_RESET
) (
  // Clock and reset
  input  wire  logic       clk,
  input  wire  logic       rst,
  // Write side
  input  wire  logic       wr_en,
  input  wire  logic [2:0] wr_data,
  // Field value
  output logic [2:0] value
);

  typedef struct packed {
    logic [2:0] cca;
  } ccr_cca_s;

  ccr_cca_s r_reg;
  ccr_cca_s r_next;

  // Read-only flavour keeps its reset value; writes are dropped
  always_comb begin
    r_next = r_reg;
    if (WRITABLE && wr_en) begin
      r_next.cca = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg.cca <= RESET_VAL;
    end else begin
      r_reg <= r_next;
    end
  end

  assign value = r_reg.cca;

endmodule

`default_nettype wire

/* design/ccr_core_config_registers.sv */
// Notes on behaviour
// RQ1: Privilege clear: window base reads zero, ignores writes
// RQ2: Enable bit 10 routes window to device logic
// RQ3: Bits 28:11 hold window physical base address
// RQ4: Bits 31:29 ignore writes, read zero
// RQ5: Control block bit 9 always reads zero
// RQ6: Block count bits 8:0, reset two
// RQ7: Coherence base bits 31:11 mirror manager field
// RQ8: Unimplemented coherence bits and 10:0 read zero
// RQ9: Bit 31 of both config words reads one
// RQ10: User/upper-kernel cacheability writable only fixed-mapping
// RQ11: Cacheability codes use the documented encoding
// RQ12: Bit 21 reflects simple byte-enable pin
// RQ13: Bit 15 reflects endianness pin
// RQ14: Burst order bit 16 reads zero
// RQ15: Architecture type 00, revision 001
// RQ16: Write merge bit 18 writable, resets one
// RQ17: Custom instruction bit follows thread config writes
// RQ18: TLB size field is entries minus one
// RQ19: Data associativity fixed four-way, code three
// RQ20: Line size zero means absent cache
// RQ21: Window register present, so capability bit set
`timescale 1ns/10ps
`default_nettype none

module ccr_core_config_registers
  import ccr_pkg::*;
#(
  parameter ccr_mmu_e                 MMU_TYPE    = MMU_FIXED,
  parameter logic [WIN_COUNT_W-1:0]   BLOCK_COUNT = WIN_COUNT_RESET,
  parameter int                       PA_BITS     = 32,
  parameter logic [5:0]               TLB_ENTRIES_M1 = 6'h0f,
  parameter logic [2:0]               ISETS       = 3'h2,
  parameter logic [2:0]               ILINE       = LINE_32B,
  parameter logic [2:0]               IASSOC      = ASSOC_4WAY,
  parameter logic [2:0]               DSETS       = 3'h2,
  parameter logic [2:0]               DLINE       = LINE_32B,
  parameter logic [6:0]               CFG1_LOW    = 7'h02,
  parameter logic                     ISPRAM      = 1'b0,
  parameter logic                     DSPRAM      = 1'b0,
  parameter logic                     CUSTOM_RESET = 1'b0
) (
  // Clock and reset
  input  wire  logic        clk,
  input  wire  logic        rst,
  // Coprocessor move port
  input  wire  logic [1:0]  cop_sel,
  input  wire  logic        cop_rd_en,
  input  wire  logic        cop_wr_en,
  input  wire  logic [31:0] cop_wdata,
  output logic [31:0] cop_rdata,
  output logic        cop_rvalid,
  // Thread context state
  input  wire  logic        multi_vpe_privilege,
  input  wire  logic        thread_cfg_wr,
  input  wire  logic        thread_cfg_custom,
  // Coherence manager base field
  input  wire  logic [COH_BASE_W-1:0] manager_base_field,
  // Static pins
  input  wire  logic        simple_byte_enable_input,
  input  wire  logic        endian_input,
  // Physical request routing
  input  wire  logic [31:0] req_paddr,
  output logic        route_to_window,
  output logic [2:0]  kernel0_cacheability,
  output logic [2:0]  user_cacheability,
  output logic [2:0]  upper_kernel_cacheability,
  output logic        device_memory_window_present
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   window_en;
    logic [WIN_BASE_W-1:0]  window_base_address;
    logic                   wc;
    logic                   write_merge_control;
    logic                   custom_instruction_flag;
    logic [1:0]             pin_sync1;
    logic [1:0]             pin_sync2;
    logic [31:0]            rdata;
    logic                   rvalid;
  } ccr_state_s;

  localparam ccr_state_s ST_RESET = '{
    window_en:               WIN_EN_RESET,
    window_base_address:     '0,
    wc:                      WC_RESET,
    write_merge_control:     MERGE_RESET,
    custom_instruction_flag: CUSTOM_RESET,
    pin_sync1:               2'h0,
    pin_sync2:               2'h0,
    rdata:                   32'h0,
    rvalid:                  1'b0
  };

  localparam logic FIXED_MAP = (MMU_TYPE == MMU_FIXED);

  ccr_state_s r_reg;
  ccr_state_s r_next;

  logic [2:0]            cca_val [3];
  logic [2:0]            cca_wdata [3];
  logic                  cfg0_wr;
  logic                  win_wr;
  logic [COH_BASE_W-1:0] coh_mask;
  logic [COH_BASE_W-1:0] coh_field;
  logic [31:0]           win_word;
  logic [31:0]           coh_word;
  logic [31:0]           cfg0_word;
  logic [31:0]           cfg1_word;
  logic [31:0]           rd_mux;
  logic                  simple_be_flag;
  logic                  endianness_flag;

  assign cfg0_wr = cop_wr_en && (cop_sel == SEL_CFG0);
  assign win_wr  = cop_wr_en && (cop_sel == SEL_WINDOW_BASE) && multi_vpe_privilege; // RQ1

  // ----------------------------------------------------------------
  // Cacheability fields: kernel0, user, upper kernel
  // ----------------------------------------------------------------
  assign cca_wdata[0] = cop_wdata[CFG0_KERN0_LSB +: 3];
  assign cca_wdata[1] = cop_wdata[CFG0_USER_LSB +: 3];
  assign cca_wdata[2] = cop_wdata[CFG0_UPKERN_LSB +: 3];

  // Under a TLB the user and upper-kernel fields are frozen at zero
  for (genvar i = 0; i < 3; i++) begin : g_cca
    ccr_cca_field #(
      .WRITABLE  ((i == 0) ? 1'b1 : FIXED_MAP),                   // RQ10
      .RESET_VAL ((i == 0 || FIXED_MAP) ? CCA_FM_RESET : CCA_TLB_VALUE)
    ) u_cca (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (cfg0_wr),
      .wr_data (cca_wdata[i]), // RQ11
      .value   (cca_val[i])
    );
  end

  assign kernel0_cacheability      = cca_val[0];
  assign user_cacheability         = cca_val[1];
  assign upper_kernel_cacheability = cca_val[2];

  // ----------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------
  assign simple_be_flag  = r_reg.pin_sync2[0];
  assign endianness_flag = r_reg.pin_sync2[1];

  // Address bits at or above PA_BITS are not implemented
  always_comb begin
    for (int b = 0; b < COH_BASE_W; b++) begin
      coh_mask[b] = ((b + COH_PA_LSB) < PA_BITS);
    end
  end
  assign coh_field = manager_base_field & coh_mask; // RQ8

  always_comb begin
    win_word = 32'h0; // RQ4
    win_word[WIN_BASE_LSB +: WIN_BASE_W] = r_reg.window_base_address; // RQ3
    win_word[WIN_EN_BIT]                 = r_reg.window_en;
    win_word[WIN_CTRL_BIT]               = 1'b0; // RQ5
    win_word[WIN_COUNT_W-1:0]            = BLOCK_COUNT; // RQ6
    if (!multi_vpe_privilege) begin
      win_word = 32'h0; // RQ1
    end
  end

  assign coh_word = {coh_field, 11'h000}; // RQ7

  always_comb begin
    cfg0_word = 32'h0;
    cfg0_word[CFG0_M_BIT]         = 1'b1; // RQ9
    cfg0_word[CFG0_UPKERN_LSB +: 3] = cca_val[2];
    cfg0_word[CFG0_USER_LSB +: 3]   = cca_val[1];
    cfg0_word[CFG0_ISP_BIT]         = ISPRAM;
    cfg0_word[CFG0_DSP_BIT]         = DSPRAM;
    cfg0_word[CFG0_CUSTOM_BIT]      = r_reg.custom_instruction_flag;
    cfg0_word[CFG0_SBE_BIT]         = simple_be_flag; // RQ12
    cfg0_word[CFG0_MDU_BIT]         = 1'b0;
    cfg0_word[CFG0_WC_BIT]          = r_reg.wc;
    cfg0_word[CFG0_MERGE_BIT]       = r_reg.write_merge_control; // RQ16
    cfg0_word[CFG0_BURST_BIT]       = BURST_SEQ; // RQ14
    cfg0_word[CFG0_ENDIAN_BIT]      = endianness_flag; // RQ13
    cfg0_word[CFG0_ATYPE_LSB +: 2]  = ARCH_TYPE_VAL; // RQ15
    cfg0_word[CFG0_AREV_LSB +: 3]   = ARCH_REV_VAL; // RQ15
    cfg0_word[CFG0_MT_LSB +: 3]     = MMU_TYPE;
    cfg0_word[CFG0_KERN0_LSB +: 3]  = cca_val[0];
  end

  always_comb begin
    cfg1_word = 32'h0;
    cfg1_word[CFG1_M_BIT]         = 1'b1; // RQ9
    cfg1_word[CFG1_TLB_LSB +: 6]  = FIXED_MAP ? 6'h00 : TLB_ENTRIES_M1; // RQ18
    cfg1_word[CFG1_IS_LSB +: 3]   = ISETS;
    // An absent instruction cache reports line size zero
    cfg1_word[CFG1_IL_LSB +: 3]   = ILINE; // RQ20
    cfg1_word[CFG1_IA_LSB +: 3]   = IASSOC;
    cfg1_word[CFG1_DS_LSB +: 3]   = DSETS;
    cfg1_word[CFG1_DL_LSB +: 3]   = DLINE; // RQ20
    cfg1_word[CFG1_DASSOC_LSB +: 3] = ASSOC_4WAY; // RQ19
    cfg1_word[6:0]                = CFG1_LOW;
  end

  always_comb begin
    case (cop_sel)
      SEL_WINDOW_BASE: rd_mux = win_word;
      SEL_COH_BASE:    rd_mux = coh_word;
      SEL_CFG0:        rd_mux = cfg0_word;
      SEL_CFG1:        rd_mux = cfg1_word;
      default:         rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.pin_sync1 = {endian_input, simple_byte_enable_input};
    r_next.pin_sync2 = r_reg.pin_sync1;
    r_next.rvalid    = cop_rd_en;
    if (cop_rd_en) begin
      r_next.rdata = rd_mux;
    end
    if (win_wr) begin
      r_next.window_en           = cop_wdata[WIN_EN_BIT]; // RQ2
      r_next.window_base_address = cop_wdata[WIN_BASE_LSB +: WIN_BASE_W]; // RQ3
    end
    if (cfg0_wr) begin
      r_next.wc                  = cop_wdata[CFG0_WC_BIT];
      // Merge control has no effect; write-through is not supported
      r_next.write_merge_control = cop_wdata[CFG0_MERGE_BIT]; // RQ16
    end
    if (thread_cfg_wr) begin
      r_next.custom_instruction_flag = thread_cfg_custom; // RQ17
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= ST_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Base is 32 KB aligned; the window spans BLOCK_COUNT+1 blocks of 64 bytes.
  // Base field bit 17 lies above a 32-bit address, so a set bit never matches.
  assign route_to_window = r_reg.window_en
                         && !r_reg.window_base_address[WIN_BASE_W-1]
                         && (req_paddr[31:WIN_ADDR_LSB] == r_reg.window_base_address[16:0])
                         && (req_paddr[14:WIN_BLOCK_LSB] <= BLOCK_COUNT); // RQ2

  assign device_memory_window_present = 1'b1; // RQ21
  assign cop_rdata  = r_reg.rdata;
  assign cop_rvalid = r_reg.rvalid;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rd_win_s;
    cop_rd_en && (cop_sel == SEL_WINDOW_BASE);
  endsequence
  sequence rd_cfg0_s;
    cop_rd_en && (cop_sel == SEL_CFG0);
  endsequence
  sequence pin_steady_s;
    $stable(endian_input) [*3];
  endsequence

  mvp_read_gate_a: assert property (rd_win_s ##0 !multi_vpe_privilege |=> cop_rdata == 32'h0) // RQ1
    else $error("window base read not zero without privilege");
  mvp_write_gate_a: assert property (cop_wr_en && (cop_sel == SEL_WINDOW_BASE)
      && !multi_vpe_privilege |=> $stable(r_reg.window_en)
      && $stable(r_reg.window_base_address)) // RQ1
    else $error("window base changed without privilege");
  window_en_write_a: assert property (win_wr |=> rd_win_s ##0 multi_vpe_privilege
      |=> cop_rdata[WIN_EN_BIT] == $past(cop_wdata[WIN_EN_BIT], 2)
      || $past(win_wr)) // RQ2
    else $error("enable bit did not take written value");
  window_fixed_bits_a: assert property (rd_win_s ##0 multi_vpe_privilege |=>
      cop_rdata[31:29] == 3'h0 && !cop_rdata[WIN_CTRL_BIT]
      && cop_rdata[8:0] == BLOCK_COUNT) // RQ4
    else $error("window base fixed fields wrong");
  route_off_a: assert property (!r_reg.window_en |-> !route_to_window) // RQ2
    else $error("routed to window while disabled");
  coh_mirror_a: assert property (cop_rd_en && (cop_sel == SEL_COH_BASE) |=>
      cop_rdata[10:0] == 11'h000 && cop_rdata[31:11] == $past(coh_field)) // RQ7
    else $error("coherence base mirror wrong");
  cfg0_fixed_a: assert property (rd_cfg0_s |=> cop_rdata[31] && !cop_rdata[16]
      && cop_rdata[14:10] == 5'h01) // RQ15
    else $error("config word 0 fixed fields wrong");
  cfg1_fixed_a: assert property (cop_rd_en && (cop_sel == SEL_CFG1) |=> cop_rdata[31]
      && cop_rdata[9:7] == 3'h3
      && (!FIXED_MAP || cop_rdata[30:25] == 6'h00)) // RQ18
    else $error("config word 1 fixed fields wrong");
  // Synchroniser holds zero for two edges after reset, so skip reads there
  endian_pin_a: assert property (pin_steady_s ##0 rd_cfg0_s ##0 !$past(rst)
      && !$past(rst, 2) |=>
      cop_rdata[15] == $past(endian_input)) // RQ13
    else $error("endianness bit does not follow pin");
  cca_tlb_lock_a: assert property (!FIXED_MAP |-> user_cacheability == 3'h0
      && upper_kernel_cacheability == 3'h0) // RQ10
    else $error("cacheability writable under TLB");
  udi_update_a: assert property (thread_cfg_wr ##1 rd_cfg0_s |=>
      cop_rdata[22] == $past(thread_cfg_custom, 2)) // RQ17
    else $error("custom instruction bit not updated");

endmodule

`default_nettype wire

/* verification/test_core_config_registers.sv */
`timescale 1ns/10ps
`default_nettype none

module test_core_config_registers
  import ccr_pkg::*;
();

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam logic [WIN_COUNT_W-1:0] BLK   = 9'h002;
  localparam int                     LIMIT = 20000;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  cop_sel = 2'h0;
  logic        cop_rd_en = 1'b0;
  logic        cop_wr_en = 1'b0;
  logic [31:0] cop_wdata = 32'h0;
  logic [31:0] cop_rdata;
  logic        cop_rvalid;
  logic        priv = 1'b1;
  logic        thread_cfg_wr = 1'b0;
  logic        thread_cfg_custom = 1'b0;
  logic [20:0] mbf = 21'h0;
  logic        sbe_in = 1'b0;
  logic        endian_in = 1'b0;
  logic [31:0] req_paddr = 32'h0;
  logic        route;
  logic [2:0]  kern0_o;
  logic [2:0]  user_o;
  logic [2:0]  upper_o;
  logic        present;

  // Reference model of the writable state
  logic [17:0] m_base;
  logic        m_en;
  logic [2:0]  m_kern0;
  logic [2:0]  m_user;
  logic [2:0]  m_upper;
  logic        m_wc;
  logic        m_merge;
  logic        m_custom;

  int          errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [31:0] r;
  logic [31:0] d;
  logic [31:0] pa;
  logic [17:0] base;
  logic [2:0]  cca_ok [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7};

  ccr_core_config_registers #(.BLOCK_COUNT(BLK)) uut (
    .clk                          (clk),
    .rst                          (rst),
    .cop_sel                      (cop_sel),
    .cop_rd_en                    (cop_rd_en),
    .cop_wr_en                    (cop_wr_en),
    .cop_wdata                    (cop_wdata),
    .cop_rdata                    (cop_rdata),
    .cop_rvalid                   (cop_rvalid),
    .multi_vpe_privilege          (priv),
    .thread_cfg_wr                (thread_cfg_wr),
    .thread_cfg_custom            (thread_cfg_custom),
    .manager_base_field           (mbf),
    .simple_byte_enable_input     (sbe_in),
    .endian_input                 (endian_in),
    .req_paddr                    (req_paddr),
    .route_to_window              (route),
    .kernel0_cacheability         (kern0_o),
    .user_cacheability            (user_o),
    .upper_kernel_cacheability    (upper_o),
    .device_memory_window_present (present)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_read(input logic [1:0] sel);
    case (sel)
      SEL_WINDOW_BASE: exp_read = priv ? {3'h0, m_base, m_en, 1'b0, BLK} : 32'h0;
      // Physical bits above 31 are not implemented, so field bits 20:17 read zero
      SEL_COH_BASE:    exp_read = {4'h0, mbf[16:0], 11'h000};
      SEL_CFG0:        exp_read = {1'b1, m_upper, m_user, 2'h0, m_custom, sbe_in, 1'b0, m_wc,
                                   m_merge, 2'h0, endian_in, 2'h0, 3'h1, 3'h3, 4'h0, m_kern0};
      default:         exp_read = {1'b1, 6'h00, 3'h2, LINE_32B, ASSOC_4WAY, 3'h2, LINE_32B,
                                   ASSOC_4WAY, 7'h02};
    endcase
  endfunction

  function automatic logic exp_route(input logic [31:0] a);
    exp_route = m_en && !m_base[17] && (a[31:15] == m_base[16:0]) && (a[14:6] <= BLK);
  endfunction

  function automatic logic [2:0] pick_cca(input logic [2:0] bits);
    pick_cca = cca_ok[int'(bits) % 5];
  endfunction

  // ----------------------------------------------------------------
  // Compare, bus and scenario tasks
  // ----------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic do_write(input logic [1:0] sel, input logic [31:0] dat);
    @(posedge clk);
    cop_sel <= sel;
    cop_wdata <= dat;
    cop_wr_en <= 1'b1;
    @(posedge clk);
    cop_wr_en <= 1'b0;
    if (sel == SEL_WINDOW_BASE && priv) begin
      m_base = dat[28:11];
      m_en = dat[10];
    end
    if (sel == SEL_CFG0) begin
      m_upper = dat[30:28];
      m_user = dat[27:25];
      m_wc = dat[19];
      m_merge = dat[18];
      m_kern0 = dat[2:0];
    end
  endtask

  task automatic read_check(input logic [1:0] sel);
    logic [31:0] mask;
    // Bit 20 of config0 is an implementation preset
    mask = (sel == SEL_CFG0) ? 32'hffef_ffff : 32'hffff_ffff;
    @(posedge clk);
    cop_sel <= sel;
    cop_rd_en <= 1'b1;
    @(posedge clk);
    cop_rd_en <= 1'b0;
    #1;
    check_bit(cop_rvalid, 1'b1);
    check_word(cop_rdata & mask, exp_read(sel) & mask);
  endtask

  task automatic check_route(input logic [31:0] a);
    @(posedge clk);
    req_paddr <= a;
    @(posedge clk);
    #1;
    check_bit(route, exp_route(a));
  endtask

  task automatic check_all();
    read_check(SEL_WINDOW_BASE);
    read_check(SEL_COH_BASE);
    read_check(SEL_CFG0);
    read_check(SEL_CFG1);
    check_word({29'h0, kern0_o}, {29'h0, m_kern0});
    check_word({26'h0, user_o, upper_o}, {26'h0, m_user, m_upper});
    check_bit(present, 1'b1);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    m_base = 18'h0;
    m_en = 1'b0;
    m_kern0 = 3'h2;
    m_user = 3'h2;
    m_upper = 3'h2;
    m_wc = 1'b0;
    m_merge = 1'b1;
    m_custom = 1'b0;
    // Static pins pass two synchroniser flops
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h7e5f));
    do_reset();
    check_all();
    // Every defined cacheability code through all three fields
    foreach (cca_ok[i]) begin
      d = {1'b0, cca_ok[i], cca_ok[i], 22'h0, cca_ok[i]};
      do_write(SEL_CFG0, d);
      check_all();
    end
    // Custom-instruction flag follows thread config writes
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      thread_cfg_wr <= 1'b1;
      thread_cfg_custom <= ~i[0];
      @(posedge clk);
      thread_cfg_wr <= 1'b0;
      m_custom = ~i[0];
      read_check(SEL_CFG0);
    end
    // Only blocks 0..BLK decode; bits 31:29 ignored; bit 28 blocks a match
    base = 18'($urandom()) & 18'h1ffff;
    do_write(SEL_WINDOW_BASE, {3'h7, base, 1'b1, 10'h3ff});
    read_check(SEL_WINDOW_BASE);
    for (int i = 0; i < 5; i++) check_route({base[16:0], 9'(i), 6'h3f});
    check_route({base[16:0] + 17'h1, 15'h0});
    do_write(SEL_WINDOW_BASE, {3'h0, 1'b1, base[16:0], 1'b1, 10'h0});
    check_route({base[16:0], 15'h0});
    do_write(SEL_WINDOW_BASE, {4'h0, base[16:0], 1'b0, 10'h0});
    check_route({base[16:0], 15'h0});
    // Without privilege the window register blanks and ignores writes
    @(posedge clk);
    priv <= 1'b0;
    do_write(SEL_WINDOW_BASE, 32'h0fff_fc00);
    read_check(SEL_WINDOW_BASE);
    check_route({base[16:0], 15'h0});
    @(posedge clk);
    priv <= 1'b1;
    read_check(SEL_WINDOW_BASE);
    // Random traffic, some words built on all-zero and all-one patterns
    repeat (200) begin
      r = $urandom();
      d = $urandom();
      @(posedge clk);
      priv <= r[0] | r[1];
      sbe_in <= r[2];
      endian_in <= r[3];
      mbf <= 21'($urandom());
      if (r[5:4] == 2'h0) d = 32'hffff_ffff;
      if (r[5:4] == 2'h1) d = 32'h0;
      d[30:28] = pick_cca(r[24:22]);
      d[27:25] = pick_cca(r[27:25]);
      d[2:0] = pick_cca(r[30:28]);
      // Diagnostic bit must be written as zero
      d[19] = 1'b0;
      if (r[8] && r[7:6] == SEL_WINDOW_BASE) d[28] = 1'b0;
      do_write(r[7:6], d);
      repeat (2) @(posedge clk);
      read_check(r[10:9]);
      pa = r[11] ? {m_base[16:0], 9'(r[15:12]), 6'(r[21:16])} : $urandom();
      check_route(pa);
      check_word({26'h0, user_o, upper_o}, {26'h0, m_user, m_upper});
    end
    // Reset in mid-run with both static pins high
    @(posedge clk);
    sbe_in <= 1'b1;
    endian_in <= 1'b1;
    do_reset();
    check_all();
    stop_test();
  end

endmodule

`default_nettype wire
